// File: pkg/cpu_exec_defines.svh
/*
 * Constants of the instruction execution block: register offsets,
 * field positions, reset values and instruction encodings.
 * Assumes inclusion by the design files by bare name.
 */
`ifndef CPU_EXEC_DEFINES_SVH
`define CPU_EXEC_DEFINES_SVH

// ****************************************************************
// register byte offsets and file window select
// ****************************************************************
`define OFF_INSTR       12'h000
`define OFF_WREG        12'h004
`define OFF_STATUS      12'h008
`define OFF_PAGE_LATCH  12'h00C
`define OFF_PC          12'h010
`define OFF_STACK_TOP   12'h014
`define OFF_STACK_PTR   12'h018
`define OFF_WATCHDOG    12'h01C
`define FILE_WIN        3'h1

// ****************************************************************
// status fields and reset values
// ****************************************************************
`define ST_ZERO         2
`define ST_POWERDOWN    3
`define ST_TIMEOUT      4
`define ST_BUSY         8
`define ST_SKIP         9
`define RST_FLAG_HIGH   1'b1
`define RST_ZERO        1'b0

// ****************************************************************
// instruction encodings
// ****************************************************************
`define ENC_AND_LIT     6'h39
`define ENC_AND_FILE    6'h05
`define ENC_SKIP_CLR    4'h6
`define ENC_SKIP_SET    4'h7
`define ENC_WATCHDOG_CLR 14'h0064
`define ENC_CALL        3'h4

// ****************************************************************
// bus responses
// ****************************************************************
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// File: pkg/cpu_exec_pkg.sv
/*
 * Types of the instruction execution block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package cpu_exec_pkg;

    typedef enum logic [2:0]
    {
        OP_NONE      = 3'h0,
        OP_AND_LIT   = 3'h1,
        OP_AND_FILE  = 3'h2,
        OP_SKIP_CLR  = 3'h3,
        OP_SKIP_SET  = 3'h4,
        OP_WATCHDOG_CLR = 3'h5,
        OP_CALL      = 3'h6
    } op_type;

    typedef enum logic [1:0]
    {
        ST_IDLE = 2'h0,
        ST_EXEC = 2'h1,
        ST_SLOT = 2'h2
    } exec_state_type;

endpackage

// File: design/file_mem.sv
/*
 * File register memory: one write port, two asynchronous read ports.
 * Assumes the owner never writes from two sources in one cycle.
 */
`timescale 1ns/1ps
`default_nettype none

module file_mem
#(
    parameter int DEPTH = 128,
    parameter int AW    = 7
)
(
    // clock
    input  wire logic          aclk,
    // write port
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [7:0]    wdata,
    // read ports
    input  wire logic [AW-1:0] raddr_a,
    output logic      [7:0]    rdata_a,
    input  wire logic [AW-1:0] raddr_b,
    output logic      [7:0]    rdata_b
);

    logic [7:0] mem [DEPTH];

    always_ff @(posedge aclk)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
    end

    assign rdata_a = mem[raddr_a];
    assign rdata_b = mem[raddr_b];

endmodule // file_mem

`default_nettype wire

// File: design/exec_alu.sv
/*
 * Instruction decode and result computation, purely combinational.
 * Assumes the file operand is already read from the addressed register.
 */
`timescale 1ns/1ps
`default_nettype none

`include "cpu_exec_defines.svh"

module exec_alu
(
    // operands
    input  wire logic [13:0]         instr,
    input  wire logic [7:0]          wreg,
    input  wire logic [7:0]          fdata,
    // decoded results
    output cpu_exec_pkg::op_type     op,
    output logic      [7:0]          result,
    output logic                     result_zero,
    output logic                     dest_file,
    output logic                     tested_bit
);
    import cpu_exec_pkg::*;

    function automatic op_type decode_op(input logic [13:0] i);
        if (i[13:8] == `ENC_AND_LIT)        return OP_AND_LIT;
        else if (i[13:8] == `ENC_AND_FILE)  return OP_AND_FILE;
        else if (i[13:10] == `ENC_SKIP_CLR) return OP_SKIP_CLR;
        else if (i[13:10] == `ENC_SKIP_SET) return OP_SKIP_SET;
        else if (i == `ENC_WATCHDOG_CLR)    return OP_WATCHDOG_CLR;
        else if (i[13:11] == `ENC_CALL)     return OP_CALL;
        else                                return OP_NONE;
    endfunction

    always_comb
    begin
        op = decode_op(instr);
        // literal operand for the literal form, file operand otherwise
        result = (op == OP_AND_LIT) ? (wreg & instr[7:0]) : (wreg & fdata);
        result_zero = (result == 8'h00);
        dest_file = instr[7];
        tested_bit = fdata[instr[9:7]];
    end

endmodule // exec_alu

`default_nettype wire

// File: design/cpu_logic_skip_call_exec.sv
/*
 * Execution logic for literal/file AND, bit test and skip, watchdog
 * clear and subroutine call, with an AXI4-Lite register slave.
 * Assumes a single clock aclk and synchronous active-low aresetn;
 * software issues one instruction per write to the instruction register.
 */
// Functional notes
// - literal AND: working register AND 8-bit literal to working register, zero flag only
// - file AND: working register AND addressed file register, only zero flag updated
// - file AND destination bit zero writes working register, one writes file register
// - skip-if-clear: tested bit zero discards next instruction as a no-op
// - skip-if-set: tested bit one discards next instruction as a no-op
// - watchdog clear zeroes the watchdog counter and its prescaler
// - watchdog clear sets the timeout and powerdown status bits
// - call pushes address of following instruction onto the return stack
// - call loads its 11-bit target into program counter bits 10 to 0
// - call fills program counter bits 12 and 11 from page latch bits 4 and 3
// - call takes two cycles, the second an idle slot
`timescale 1ns/1ps
`default_nettype none

`include "cpu_exec_defines.svh"

module cpu_logic_skip_call_exec
#(
    parameter int ADDR_W      = 12,
    parameter int STACK_DEPTH = 8,
    parameter int WDT_W       = 8,
    parameter int PRE_W       = 8
)
(
    // clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // write address
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic [2:0]        awprot,
    input  wire logic              awvalid,
    output logic                   awready,
    // write data
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    // write response
    output logic      [1:0]        bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    // read address
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic [2:0]        arprot,
    input  wire logic              arvalid,
    output logic                   arready,
    // read data
    output logic      [31:0]       rdata,
    output logic      [1:0]        rresp,
    output logic                   rvalid,
    input  wire logic              rready
);
    import cpu_exec_pkg::*;

    localparam int SP_W = $clog2(STACK_DEPTH);

    // ****************************************************************
    // state
    // ****************************************************************
    exec_state_type    state;
    logic [13:0]       instr;
    logic [7:0]        wreg;
    logic              zero;
    logic              timeout_flag;
    logic              powerdown_flag;
    logic [4:0]        pc_page_latch;
    logic [12:0]       program_counter;
    logic [12:0]       stack_mem [STACK_DEPTH];
    logic [SP_W-1:0]   stack_ptr;
    logic [12:0]       stack_top;
    logic              skip_pending;
    logic [WDT_W-1:0]  watchdog_counter;
    logic [PRE_W-1:0]  watchdog_prescale;
    logic [ADDR_W-1:0] aw_addr;
    logic              aw_full;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              w_full;
    op_type            op;
    logic [7:0]        result;
    logic              result_zero;
    logic              dest_file;
    logic              tested_bit;
    logic [7:0]        fdata_exec;
    logic [7:0]        fdata_rd;
    logic              commit;
    logic              exec_fire;
    logic              live;
    logic [31:0]       wr_val;
    logic              file_we;

    function automatic logic [12:0] pc_plus_one(input logic [12:0] p);
        return p + 13'h0001;
    endfunction

    function automatic logic is_file(input logic [ADDR_W-1:0] a);
        return (a[11:9] == `FILE_WIN) && (a[1:0] == 2'h0);
    endfunction

    function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
        return is_file(a) || (a <= `OFF_WATCHDOG && a[1:0] == 2'h0);
    endfunction

    // current word at an address; file data supplied by the caller
    function automatic logic [31:0] read_mux(input logic [ADDR_W-1:0] a,
                                             input logic [7:0] f);
        logic [31:0] v;
        v = 32'h0000_0000;
        if (is_file(a))
            v[7:0] = f;
        else
        begin
            unique case (a)
                `OFF_INSTR:      v[13:0] = instr;
                `OFF_WREG:       v[7:0] = wreg;
                `OFF_STATUS:
                begin
                    v[`ST_ZERO] = zero;
                    v[`ST_POWERDOWN] = powerdown_flag;
                    v[`ST_TIMEOUT] = timeout_flag;
                    v[`ST_BUSY] = (state != ST_IDLE);
                    v[`ST_SKIP] = skip_pending;
                end
                `OFF_PAGE_LATCH: v[4:0] = pc_page_latch;
                `OFF_PC:         v[12:0] = program_counter;
                `OFF_STACK_TOP:  v[12:0] = stack_top;
                `OFF_STACK_PTR:  v[SP_W-1:0] = stack_ptr;
                `OFF_WATCHDOG:   v[15:0] = {8'(watchdog_prescale), 8'(watchdog_counter)};
                default:         v = 32'h0000_0000;
            endcase
        end
        return v;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                          input logic [3:0] s);
        logic [31:0] m;
        m = o;
        for (int i = 0; i < 4; i++)
            if (s[i])
                m[i*8 +: 8] = n[i*8 +: 8];
        return m;
    endfunction

    // ****************************************************************
    // datapath instances
    // ****************************************************************
    exec_alu u_alu
    (
        .instr       (instr),
        .wreg        (wreg),
        .fdata       (fdata_exec),
        .op          (op),
        .result      (result),
        .result_zero (result_zero),
        .dest_file   (dest_file),
        .tested_bit  (tested_bit)
    );

    file_mem u_file
    (
        .aclk    (aclk),
        .we      (file_we),
        .waddr   (exec_fire ? instr[6:0] : aw_addr[8:2]),
        .wdata   (exec_fire ? result : wr_val[7:0]),
        .raddr_a (exec_fire ? instr[6:0] : aw_addr[8:2]),
        .rdata_a (fdata_exec),
        .raddr_b (araddr[8:2]),
        .rdata_b (fdata_rd)
    );

    // bus writes commit only while idle, so they never meet an execution
    assign commit = aw_full && w_full && !bvalid && (state == ST_IDLE);
    assign exec_fire = (state == ST_EXEC);
    assign live = exec_fire && !skip_pending;
    // a process, not an assign, so register changes seen inside read_mux re-evaluate it
    always_comb
    begin
        wr_val = merge(read_mux(aw_addr, fdata_exec), w_data, w_strb);
    end
    assign stack_top = stack_mem[stack_ptr - SP_W'(1)];
    assign file_we = (live && op == OP_AND_FILE && dest_file)
                   || (commit && is_file(aw_addr));

    // ****************************************************************
    // AXI4-Lite write channels
    // ****************************************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_full <= 1'b0;
            awready <= 1'b1;
            aw_addr <= '0;
        end
        else if (awvalid && awready)
        begin
            aw_full <= 1'b1;
            awready <= 1'b0;
            aw_addr <= awaddr;
        end
        else if (commit)
        begin
            aw_full <= 1'b0;
            awready <= 1'b1;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            w_full <= 1'b0;
            wready <= 1'b1;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end
        else if (wvalid && wready)
        begin
            w_full <= 1'b1;
            wready <= 1'b0;
            w_data <= wdata;
            w_strb <= wstrb;
        end
        else if (commit)
        begin
            w_full <= 1'b0;
            wready <= 1'b1;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid <= 1'b0;
            bresp <= `RESP_OKAY;
        end
        else if (commit)
        begin
            bvalid <= 1'b1;
            bresp <= addr_hit(aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
        end
        else if (bready)
        begin
            bvalid <= 1'b0;
        end
    end

    // ****************************************************************
    // AXI4-Lite read channels
    // ****************************************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= `RESP_OKAY;
        end
        else if (arvalid && arready)
        begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= addr_hit(araddr) ? read_mux(araddr, fdata_rd) : 32'h0000_0000;
            rresp <= addr_hit(araddr) ? `RESP_OKAY : `RESP_SLVERR;
        end
        else if (rvalid && rready)
        begin
            arready <= 1'b1;
            rvalid <= 1'b0;
        end
    end

    // ****************************************************************
    // instruction sequencing
    // ****************************************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            instr <= 14'h0000;
        else if (commit && aw_addr == `OFF_INSTR)
            instr <= wr_val[13:0];
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            state <= ST_IDLE;
        else
        begin
            unique case (state)
                ST_IDLE: if (commit && aw_addr == `OFF_INSTR) state <= ST_EXEC;
                ST_EXEC: state <= (live && op == OP_CALL) ? ST_SLOT : ST_IDLE;
                ST_SLOT: state <= ST_IDLE;
                default: state <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            skip_pending <= 1'b0;
        else if (live && op == OP_SKIP_CLR && !tested_bit)
            skip_pending <= 1'b1;
        else if (live && op == OP_SKIP_SET && tested_bit)
            skip_pending <= 1'b1;
        else if (exec_fire)
            skip_pending <= 1'b0;
    end

    // ****************************************************************
    // working register and status
    // ****************************************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            wreg <= 8'h00;
        else if (live && (op == OP_AND_LIT || (op == OP_AND_FILE && !dest_file)))
            wreg <= result;
        else if (commit && aw_addr == `OFF_WREG)
            wreg <= wr_val[7:0];
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            zero <= `RST_ZERO;
        else if (live && (op == OP_AND_LIT || op == OP_AND_FILE))
            zero <= result_zero;
        else if (commit && aw_addr == `OFF_STATUS)
            zero <= wr_val[`ST_ZERO];
    end

    // software may clear these; the instruction set wins over any clear
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            timeout_flag <= `RST_FLAG_HIGH;
            powerdown_flag <= `RST_FLAG_HIGH;
        end
        else if (live && op == OP_WATCHDOG_CLR)
        begin
            timeout_flag <= 1'b1;
            powerdown_flag <= 1'b1;
        end
        else if (commit && aw_addr == `OFF_STATUS)
        begin
            timeout_flag <= wr_val[`ST_TIMEOUT];
            powerdown_flag <= wr_val[`ST_POWERDOWN];
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            watchdog_prescale <= '0;
            watchdog_counter <= '0;
        end
        else if (live && op == OP_WATCHDOG_CLR)
        begin
            watchdog_prescale <= '0;
            watchdog_counter <= '0;
        end
        else
        begin
            watchdog_prescale <= watchdog_prescale + PRE_W'(1);
            if (&watchdog_prescale)
                watchdog_counter <= watchdog_counter + WDT_W'(1);
        end
    end

    // ****************************************************************
    // program counter and return stack
    // ****************************************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            pc_page_latch <= 5'h00;
        else if (commit && aw_addr == `OFF_PAGE_LATCH)
            pc_page_latch <= wr_val[4:0];
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            program_counter <= 13'h0000;
        else if (live && op == OP_CALL)
            program_counter <= {pc_page_latch[4:3], instr[10:0]};
        else if (exec_fire)
            program_counter <= pc_plus_one(program_counter);
        else if (commit && aw_addr == `OFF_PC)
            program_counter <= wr_val[12:0];
    end

    // the stack wraps on overflow, as a fixed-depth hardware stack does
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            stack_ptr <= '0;
        else if (live && op == OP_CALL)
        begin
            stack_mem[stack_ptr] <= pc_plus_one(program_counter);
            stack_ptr <= stack_ptr + SP_W'(1);
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_live(op_type o);
        state == ST_EXEC && !skip_pending && op == o;
    endsequence

    sequence s_live_dest(op_type o, logic d);
        state == ST_EXEC && !skip_pending && op == o && dest_file == d;
    endsequence

    sequence s_call_slot;
        state == ST_SLOT ##1 state == ST_IDLE;
    endsequence

    AST_AND_LIT: assert property (s_live(OP_AND_LIT) |=> wreg == ($past(wreg) & $past(instr[7:0])) && zero == (wreg == 8'h00))
        else $error("literal AND result wrong");
    AST_AND_FILE_W: assert property (s_live_dest(OP_AND_FILE, 1'b0) |=>
            wreg == ($past(wreg) & $past(fdata_exec)) && zero == (wreg == 8'h00))
        else $error("file AND to working register wrong");
    AST_AND_FILE_F: assert property (s_live_dest(OP_AND_FILE, 1'b1) |-> file_we ##1
            $stable(wreg) && u_file.mem[$past(instr[6:0])] == ($past(wreg) & $past(fdata_exec)))
        else $error("file AND to file register wrong");
    AST_SKIP_CLR: assert property (s_live(OP_SKIP_CLR) |=> skip_pending == !$past(tested_bit))
        else $error("skip if clear wrong");
    AST_SKIP_SET: assert property (s_live(OP_SKIP_SET) |=> skip_pending == $past(tested_bit))
        else $error("skip if set wrong");
    AST_WATCHDOG_ZERO: assert property (s_live(OP_WATCHDOG_CLR) |=>
            watchdog_counter == '0 && watchdog_prescale == '0)
        else $error("watchdog not cleared");
    AST_WATCHDOG_FLAGS: assert property (s_live(OP_WATCHDOG_CLR) |=>
            timeout_flag && powerdown_flag)
        else $error("timeout or powerdown not set");
    AST_CALL_PUSH: assert property (s_live(OP_CALL) |=> stack_top == $past(program_counter) + 13'h0001)
        else $error("return address not pushed");
    AST_CALL_TARGET: assert property (s_live(OP_CALL) |=> program_counter == {$past(pc_page_latch[4:3]), $past(instr[10:0])})
        else $error("call target wrong");
    AST_CALL_PAGE: assert property (s_live(OP_CALL) |=> program_counter[12:11] == $past(pc_page_latch[4:3]))
        else $error("call page bits wrong");
    AST_CALL_SLOT: assert property (s_live(OP_CALL) |=> s_call_slot)
        else $error("call not two cycles");
    AST_DISCARD: assert property (state == ST_EXEC && skip_pending |-> !file_we ##1 $stable(wreg) && $stable(zero) && !skip_pending)
        else $error("discarded slot had side effects");

endmodule // cpu_logic_skip_call_exec

`default_nettype wire

// File: sim/cpu_logic_skip_call_exec_tb.sv
/*
 * Testbench of the execution block: bus tasks and instruction sequences.
 * Assumes the design package and header are compiled ahead of this file.
 */
`timescale 1ns/1ps
`default_nettype none

module cpu_logic_skip_call_exec_tb;

    // ****************************************************************
    // signals and clock
    // ****************************************************************
    logic        aclk, aresetn;
    logic [11:0] awaddr, araddr;
    logic [2:0]  awprot, arprot;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata, d;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, rr;
    int          failures, comparisons, cycles;

    initial
    begin
        aclk = 1'h0;
        forever #10 aclk = ~aclk;
    end

    cpu_logic_skip_call_exec u_cpu_logic_skip_call_exec
    (
        .aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awprot(awprot), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arprot(arprot), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready)
    );

    // ****************************************************************
    // bus tasks
    // ****************************************************************
    task chk(input logic [31:0] seen, input logic [31:0] want);
        comparisons++;
        if (seen !== want)
        begin
            failures++;
            $display("unexpected at %0t: got %h, wanted %h", $time, seen, want);
        end
    endtask

    task wr(input logic [11:0] a, input logic [31:0] v);
        awaddr  <= a;
        wdata   <= v;
        awvalid <= 1'h1;
        wvalid  <= 1'h1;
        bready  <= 1'h1;
        do
        begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
        end while (!bvalid);
        bready <= 1'h0;
        chk({30'h0, bresp}, 32'h0);
        @(posedge aclk);
    endtask

    task rd(input logic [11:0] a);
        araddr  <= a;
        arvalid <= 1'h1;
        rready  <= 1'h1;
        do
        begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'h0;
        end while (!rvalid);
        d = rdata;
        rr = rresp;
        rready <= 1'h0;
        @(posedge aclk);
    endtask

    task rc(input logic [11:0] a, input logic [31:0] want);
        rd(a);
        chk(d, want);
    endtask

    task complete_run;
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    always @(posedge aclk)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            failures++;
            complete_run;
        end
    end

    // ****************************************************************
    // test sequence
    // ****************************************************************
    initial
    begin
        {aresetn, awaddr, araddr, awprot, arprot, wdata} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        wstrb = 4'hF;
        failures = 0;
        comparisons = 0;
        cycles = 0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        rc(12'h008, 32'h18);
        rd(12'h020);
        chk({30'h0, rr}, 32'h2);
        // literal and, both results; zero flag checked only when set
        wr(12'h004, 32'hF3);
        wr(12'h000, 32'h393C);
        rc(12'h004, 32'h30);
        wr(12'h000, 32'h390C);
        rc(12'h004, 32'h00);
        rc(12'h008, 32'h1C);
        // file and, both destinations
        wr(12'h214, 32'hA5);
        wr(12'h004, 32'h3C);
        wr(12'h000, 32'h0505);
        rc(12'h004, 32'h24);
        rc(12'h214, 32'hA5);
        rc(12'h008, 32'h18);
        wr(12'h004, 32'h5A);
        wr(12'h000, 32'h0585);
        rc(12'h214, 32'h00);
        rc(12'h004, 32'h5A);
        rc(12'h008, 32'h1C);
        // every bit, both polarities; a following and with zero shows the skip
        wr(12'h214, 32'hA5);
        for (int i = 0; i < 16; i++)
        begin
            wr(12'h004, 32'h5A);
            wr(12'h000, 32'h1805 | (i << 7));
            wr(12'h000, 32'h3900);
            rc(12'h004, (((8'hA5 >> (i % 8)) & 1) == (i / 8)) ? 32'h5A : 32'h0);
        end
        // watchdog clear after the counter has advanced
        repeat (300) @(posedge aclk);
        wr(12'h008, 32'h0);
        wr(12'h000, 32'h0064);
        rc(12'h008, 32'h18);
        rd(12'h01C);
        chk(d & 32'hFFFFF0FF, 32'h0);
        // call with only latch bits 4 and 3 reaching the upper counter
        wr(12'h00C, 32'h17);
        wr(12'h010, 32'h123);
        wr(12'h000, 32'h27FF);
        rc(12'h010, 32'h17FF);
        rc(12'h014, 32'h124);
        rc(12'h018, 32'h1);
        // an undecoded code only steps the program counter
        wr(12'h000, 32'h0000);
        rc(12'h010, 32'h1800);
        complete_run;
    end

endmodule // cpu_logic_skip_call_exec_tb

`default_nettype wire
